// ### core/ptp_event_trigger_regs.sv
// Purpose: paged register port for event timestamp readout and trigger configuration
// Assumes: capture logic and trigger engine run on CLK; host register port on CLK
// Notes: read data is registered, valid one cycle after the read strobe
//
// Behaviour
// - extended status: unit n detect at bit 2n, edge direction at 2n+1
// - detect flag set only for units captured at this timestamp
// - extended flags reset to zero, read-only, cleared after being read
// - each timestamp-phase data read returns one 16-bit timestamp slice
// - trigger register reachable only when page select low bits are 101
// - write with commit bit loads control fields into selected trigger
// - write with commit zero selects; next read returns that trigger's config
// - commit bit self-clears and always reads zero
// - pulse control makes the trigger emit a pulse, not an edge
// - periodic control gives repeating output, else one pulse or edge
// - fire-when-overdue fires at once when trigger time already passed
// - periodic overdue start gives no notification
// - report enable reports completion or late error, may interrupt
// - route field 1..12 connects trigger to GPIO 1..12; 0 and 13..15 disconnect
// - toggle mode ignores initial level and inverts output at time
// - trigger register bits 6:4 ignore writes and read zero
// - select field bits 3:1 picks configuration target trigger
// - with multiple events, extended status is first data read
// - slices: ns low, ns 29:16 upper bits zero, sec low, sec high
// - status read advances to next queued event; read before data
`timescale 1ns/1ps
`default_nettype none
module ptp_event_trigger_regs
    import ptp_regs_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [ptp_regs_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [ptp_regs_pkg::DATA_W-1:0] REG_WDATA,
    output logic [ptp_regs_pkg::DATA_W-1:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic EVT_VALID,
    output logic EVT_READY,
    input wire logic [ptp_regs_pkg::NUM_UNITS-1:0] EVT_SEEN,
    input wire logic [ptp_regs_pkg::NUM_UNITS-1:0] EVT_DIR,
    input wire logic [2:0] EVT_MISSED,
    input wire logic [ptp_regs_pkg::NS_W-1:0] EVT_NS,
    input wire logic [ptp_regs_pkg::SEC_W-1:0] EVT_SEC,
    input wire logic [ptp_regs_pkg::NUM_TRIG-1:0] TRIG_TIME_PASSED,
    input wire logic [ptp_regs_pkg::NUM_TRIG-1:0] TRIG_DONE,
    input wire logic [ptp_regs_pkg::NUM_TRIG-1:0] TRIG_LATE_ERR,
    input wire logic [ptp_regs_pkg::NUM_TRIG-1:0] TRIG_LEVEL,
    output logic [ptp_regs_pkg::NUM_TRIG*ptp_regs_pkg::CFG_W-1:0] TRIG_CFG,
    output logic [ptp_regs_pkg::NUM_TRIG-1:0] TRIG_FIRE_NOW,
    output logic [ptp_regs_pkg::NUM_TRIG-1:0] TRIG_REPORT,
    output logic [ptp_regs_pkg::NUM_GPIO-1:0] GPIO_OUT
);
    import ptp_regs_pkg::*;

    // ==========================================================
    // page select and decode
    logic [2:0] page_reg, page_next;
    logic on_event_page, on_cfg_page;
    logic rd_sts, rd_data, acc_trig;

    assign on_event_page = (page_reg == PAGE_EVENT);
    assign on_cfg_page = (page_reg == PAGE_CFG);
    assign rd_sts = REG_RD && on_event_page && (REG_ADDR == EVT_STS_ADDR);
    assign rd_data = REG_RD && on_event_page && (REG_ADDR == EVT_DATA_ADDR);
    assign acc_trig = on_cfg_page && (REG_ADDR == TRIG_CFG_ADDR);

    always_comb begin
        page_next = page_reg;
        if (REG_WR && (REG_ADDR == PAGE_SEL_ADDR)) begin
            page_next = REG_WDATA[2:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            page_reg <= PAGE_RST;
        end else begin
            page_reg <= page_next;
        end
    end

    // ==========================================================
    // event queue: one pending slot fed by capture, one slot under readout
    logic pend_reg, pend_next;
    logic [NUM_UNITS-1:0] pseen_reg, pseen_next, pdir_reg, pdir_next;
    logic [2:0] pmiss_reg, pmiss_next;
    logic [NS_W-1:0] pns_reg, pns_next;
    logic [SEC_W-1:0] psec_reg, psec_next;
    logic cur_reg, cur_next;
    logic [NUM_UNITS-1:0] cseen_reg, cseen_next, cdir_reg, cdir_next;
    logic [2:0] cmiss_reg, cmiss_next;
    logic [NS_W-1:0] cns_reg, cns_next;
    logic [SEC_W-1:0] csec_reg, csec_next;
    logic [DATA_W-1:0] ext_reg, ext_next;
    phase_t phase_reg, phase_next;
    logic evt_ready_reg, evt_ready_next;
    logic take_evt;

    // capture is refused while the pending slot is full; the status read frees it
    assign take_evt = EVT_VALID && evt_ready_reg;

    always_comb begin
        pend_next = pend_reg;
        pseen_next = pseen_reg;
        pdir_next = pdir_reg;
        pmiss_next = pmiss_reg;
        pns_next = pns_reg;
        psec_next = psec_reg;
        cur_next = cur_reg;
        cseen_next = cseen_reg;
        cdir_next = cdir_reg;
        cmiss_next = cmiss_reg;
        cns_next = cns_reg;
        csec_next = csec_reg;
        ext_next = ext_reg;
        phase_next = phase_reg;
        if (rd_sts) begin
            cur_next = pend_reg;
            cseen_next = pend_reg ? pseen_reg : '0;
            cdir_next = pend_reg ? pdir_reg : '0;
            cmiss_next = pend_reg ? pmiss_reg : '0;
            cns_next = pns_reg;
            csec_next = psec_reg;
            ext_next = '0;
            for (int n = 0; n < NUM_UNITS; n++) begin
                ext_next[2*n] = pend_reg & pseen_reg[n];
                ext_next[2*n+1] = pend_reg & pseen_reg[n] & pdir_reg[n];
            end
            phase_next = (pend_reg && ($countones(pseen_reg) > 1)) ? PH_EXT : PH_NS_LO;
            pend_next = 1'b0;
        end else if (rd_data) begin
            case (phase_reg)
                PH_EXT: begin
                    ext_next = '0;
                    phase_next = PH_NS_LO;
                end
                PH_NS_LO: phase_next = PH_NS_HI;
                PH_NS_HI: phase_next = PH_SEC_LO;
                PH_SEC_LO: phase_next = PH_SEC_HI;
                PH_SEC_HI: phase_next = PH_NS_LO;
                default: phase_next = PH_NS_LO;
            endcase
        end
        if (take_evt) begin
            pend_next = 1'b1;
            pseen_next = EVT_SEEN;
            pdir_next = EVT_DIR;
            pmiss_next = EVT_MISSED;
            pns_next = EVT_NS;
            psec_next = EVT_SEC;
        end
        evt_ready_next = !pend_next;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            pend_reg <= 1'b0;
            pseen_reg <= '0;
            pdir_reg <= '0;
            pmiss_reg <= '0;
            pns_reg <= '0;
            psec_reg <= '0;
            cur_reg <= 1'b0;
            cseen_reg <= '0;
            cdir_reg <= '0;
            cmiss_reg <= '0;
            cns_reg <= '0;
            csec_reg <= '0;
            ext_reg <= '0;
            phase_reg <= PH_NS_LO;
            evt_ready_reg <= 1'b0;
        end else begin
            pend_reg <= pend_next;
            pseen_reg <= pseen_next;
            pdir_reg <= pdir_next;
            pmiss_reg <= pmiss_next;
            pns_reg <= pns_next;
            psec_reg <= psec_next;
            cur_reg <= cur_next;
            cseen_reg <= cseen_next;
            cdir_reg <= cdir_next;
            cmiss_reg <= cmiss_next;
            cns_reg <= cns_next;
            csec_reg <= csec_next;
            ext_reg <= ext_next;
            phase_reg <= phase_next;
            evt_ready_reg <= evt_ready_next;
        end
    end

    // status word from the pending slot, for the event the status read moves under readout
    logic [DATA_W-1:0] sts_word;
    logic [2:0] low_unit;

    always_comb begin
        low_unit = 3'h0;
        for (int n = NUM_UNITS - 1; n >= 0; n--) begin
            if (pseen_reg[n]) begin
                low_unit = 3'(n);
            end
        end
        sts_word = '0;
        if (pend_reg) begin
            sts_word[STS_DET_BIT] = 1'b1;
            sts_word[STS_MULT_BIT] = ($countones(pseen_reg) > 1);
            sts_word[STS_NUM_LSB +: 3] = low_unit;
            sts_word[STS_RF_BIT] = pdir_reg[low_unit];
            sts_word[STS_LEN_LSB +: 2] = TS_LEN_ALL;
            sts_word[STS_MISSED_LSB +: 3] = pmiss_reg;
        end
    end

    // ==========================================================
    // trigger configuration port
    trig_cfg_if #(.NUM(NUM_TRIG), .W(CFG_W)) cfg_bus();

    trig_cfg_bank #(.NUM(NUM_TRIG), .W(CFG_W)) u_bank (
        .CLK(CLK),
        .RST(RST),
        .cfg(cfg_bus.bank)
    );

    logic [2:0] sel_reg, sel_next;

    always_comb begin
        sel_next = sel_reg;
        if (REG_WR && acc_trig) begin
            sel_next = REG_WDATA[SEL_LSB +: 3];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            sel_reg <= 3'h0;
        end else begin
            sel_reg <= sel_next;
        end
    end

    // write goes straight to the bank so the commit bit is never stored
    assign cfg_bus.wr_en = REG_WR && acc_trig && REG_WDATA[COMMIT_BIT];
    assign cfg_bus.wdata = REG_WDATA[CFG_LSB +: CFG_W];
    assign cfg_bus.sel = cfg_bus.wr_en ? REG_WDATA[SEL_LSB +: 3] : sel_reg;

    // ==========================================================
    // read data
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;

    always_comb begin
        rdata_next = '0;
        rvalid_next = REG_RD;
        if (REG_RD) begin
            if (REG_ADDR == PAGE_SEL_ADDR) begin
                rdata_next = {13'h0000, page_reg};
            end else if (rd_sts) begin
                rdata_next = sts_word;
            end else if (rd_data && cur_reg) begin
                case (phase_reg)
                    PH_EXT: rdata_next = ext_reg;
                    PH_NS_LO: rdata_next = cns_reg[15:0];
                    PH_NS_HI: rdata_next = {2'h0, cns_reg[29:16]};
                    PH_SEC_LO: rdata_next = csec_reg[15:0];
                    PH_SEC_HI: rdata_next = csec_reg[31:16];
                    default: rdata_next = '0;
                endcase
            end else if (acc_trig) begin
                // bits 6:4 and commit bit read zero
                rdata_next = {cfg_bus.rdata, 3'h0, sel_reg, 1'b0};
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ==========================================================
    // trigger engine hooks: routing, overdue start, reporting
    logic [NUM_GPIO-1:0] gpio_reg, gpio_next;
    logic [NUM_TRIG-1:0] fire_reg, fire_next, rep_reg, rep_next;
    logic [CFG_W-1:0] f;

    always_comb begin
        gpio_next = '0;
        fire_next = '0;
        rep_next = '0;
        f = '0;
        for (int t = 0; t < NUM_TRIG; t++) begin
            f = cfg_bus.cfg_all[t*CFG_W +: CFG_W];
            for (int g = 1; g <= NUM_GPIO; g++) begin
                if (int'(f[F_ROUTE_LSB +: 4]) == g) begin
                    gpio_next[g-1] = gpio_next[g-1] | TRIG_LEVEL[t];
                end
            end
            fire_next[t] = f[F_OVERDUE] & TRIG_TIME_PASSED[t];
            // late periodic start with overdue firing is silent
            rep_next[t] = f[F_REPORT] & (TRIG_DONE[t] |
                (TRIG_LATE_ERR[t] & ~(f[F_PERIODIC] & f[F_OVERDUE])));
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            gpio_reg <= '0;
            fire_reg <= '0;
            rep_reg <= '0;
        end else begin
            gpio_reg <= gpio_next;
            fire_reg <= fire_next;
            rep_reg <= rep_next;
        end
    end

    // pulse, periodic and toggle bits are consumed by the engine from TRIG_CFG
    assign TRIG_CFG = cfg_bus.cfg_all;
    assign TRIG_FIRE_NOW = fire_reg;
    assign TRIG_REPORT = rep_reg;
    assign GPIO_OUT = gpio_reg;
    assign REG_RDATA = rdata_reg;
    assign REG_RVALID = rvalid_reg;
    assign EVT_READY = evt_ready_reg;
endmodule
`default_nettype wire

// ### core/ptp_regs_pkg.sv
// Purpose: shared constants and types for the event readout and trigger config block
// Assumes: 16-bit management registers in a paged 5-bit address space
// Notes: offsets and field positions live here only
package ptp_regs_pkg;

    // ==========================================================
    // register space
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam logic [4:0] PAGE_SEL_ADDR = 5'h13;
    localparam logic [4:0] TRIG_CFG_ADDR = 5'h14;
    localparam logic [4:0] EVT_STS_ADDR = 5'h1e;
    localparam logic [4:0] EVT_DATA_ADDR = 5'h1f;
    localparam logic [2:0] PAGE_EVENT = 3'h4;
    localparam logic [2:0] PAGE_CFG = 3'h5;
    localparam logic [2:0] PAGE_RST = 3'h0;

    // ==========================================================
    // event units and timestamp
    localparam int NUM_UNITS = 8;
    localparam int NS_W = 30;
    localparam int SEC_W = 32;
    localparam logic [1:0] TS_LEN_ALL = 2'h3;
    localparam int STS_DET_BIT = 0;
    localparam int STS_MULT_BIT = 1;
    localparam int STS_NUM_LSB = 2;
    localparam int STS_RF_BIT = 5;
    localparam int STS_LEN_LSB = 6;
    localparam int STS_MISSED_LSB = 8;

    // ==========================================================
    // trigger configuration word
    localparam int NUM_TRIG = 8;
    localparam int NUM_GPIO = 12;
    localparam int CFG_W = 9;
    localparam int CFG_LSB = 7;
    localparam int SEL_LSB = 1;
    localparam int COMMIT_BIT = 0;
    localparam logic [8:0] CFG_RST = 9'h000;
    // positions inside the stored 9-bit field group (bits 15:7 of the word)
    localparam int F_PULSE = 8;
    localparam int F_PERIODIC = 7;
    localparam int F_OVERDUE = 6;
    localparam int F_REPORT = 5;
    localparam int F_ROUTE_LSB = 1;
    localparam int F_TOGGLE = 0;

    // ==========================================================
    // event data read phase
    typedef enum logic [4:0] {
        PH_EXT = 5'b00001,
        PH_NS_LO = 5'b00010,
        PH_NS_HI = 5'b00100,
        PH_SEC_LO = 5'b01000,
        PH_SEC_HI = 5'b10000
    } phase_t;

endpackage

// ### core/trig_cfg_bank.sv
// Purpose: per-trigger configuration store
// Assumes: writer holds sel and wdata valid in the cycle of wr_en
// Notes: readback is combinational from the flops
`timescale 1ns/1ps
`default_nettype none
module trig_cfg_bank
    import ptp_regs_pkg::*;
#(
    parameter int NUM = 8,
    parameter int W = 9
) (
    input wire logic CLK,
    input wire logic RST,
    trig_cfg_if.bank cfg
);
    logic [W-1:0] cfg_reg [NUM];
    logic [W-1:0] cfg_next [NUM];

    always_comb begin
        for (int i = 0; i < NUM; i++) begin
            cfg_next[i] = cfg_reg[i];
            if (cfg.wr_en && (int'(cfg.sel) == i)) begin
                cfg_next[i] = cfg.wdata;
            end
        end
    end

    always_ff @(posedge CLK) begin
        for (int i = 0; i < NUM; i++) begin
            if (RST) begin
                cfg_reg[i] <= W'(CFG_RST);
            end else begin
                cfg_reg[i] <= cfg_next[i];
            end
        end
    end

    always_comb begin
        cfg.rdata = cfg_reg[cfg.sel];
        for (int i = 0; i < NUM; i++) begin
            cfg.cfg_all[i*W +: W] = cfg_reg[i];
        end
    end
endmodule
`default_nettype wire

// ### core/trig_cfg_if.sv
// Purpose: carries trigger configuration traffic between register logic and the bank
// Assumes: one write or select per cycle
// Notes: cfg_all is the flattened store, trigger 0 in the low bits
`timescale 1ns/1ps
`default_nettype none
interface trig_cfg_if #(parameter int NUM = 8, parameter int W = 9);
    logic wr_en;
    logic [2:0] sel;
    logic [W-1:0] wdata;
    logic [W-1:0] rdata;
    logic [NUM*W-1:0] cfg_all;

    modport bank(input wr_en, input sel, input wdata, output rdata, output cfg_all);
    modport ctrl(output wr_en, output sel, output wdata, input rdata, input cfg_all);
endinterface
`default_nettype wire

// ### verif/ptp_event_readout_trigger_config_tb.sv
// Purpose: self-checking bench for the event readout and trigger config block
// Assumes: host strobes and trigger inputs driven on the falling edge
// Notes: trigger expectations come from an integer model of the trigger store; event expectations come from the offered fields
`timescale 1ns/1ps
`default_nettype none
module ptp_event_readout_trigger_config_tb;
    import ptp_regs_pkg::*;
    logic clk, rst, reg_wr, reg_rd, reg_rvalid, evt_valid, evt_ready;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd_val, w, st, ext;
    logic [7:0] seen, dir, passed, done, late, level, fire_now, report, s, d, fe, re;
    logic [2:0] missed, m, num;
    logic [29:0] ns, n;
    logic [31:0] sec, sc;
    logic [71:0] trig_cfg, cv;
    logic [11:0] gpio, ge;
    int errors, samples_checked, c;
    int cfg_m[8];

    ptp_event_trigger_regs ptp_event_trigger_regs_i (.CLK(clk), .RST(rst), .REG_ADDR(reg_addr),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .REG_RVALID(reg_rvalid), .EVT_VALID(evt_valid), .EVT_READY(evt_ready), .EVT_SEEN(seen),
        .EVT_DIR(dir), .EVT_MISSED(missed), .EVT_NS(ns), .EVT_SEC(sec),
        .TRIG_TIME_PASSED(passed), .TRIG_DONE(done), .TRIG_LATE_ERR(late), .TRIG_LEVEL(level),
        .TRIG_CFG(trig_cfg), .TRIG_FIRE_NOW(fire_now), .TRIG_REPORT(report), .GPIO_OUT(gpio));
    ptp_evt_source ptp_evt_source_i (.CLK(clk), .EVT_READY(evt_ready), .EVT_VALID(evt_valid),
        .EVT_SEEN(seen), .EVT_DIR(dir), .EVT_MISSED(missed), .EVT_NS(ns), .EVT_SEC(sec));

    // ==========================================================
    // tasks
    task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] dt);
        reg_addr = a;
        reg_wdata = dt;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        // idle cycle: a following call never re-raises a strobe in the same step
        @(negedge clk);
    endtask
    task automatic rd(input logic [4:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk("rvalid", 72'h1, 72'(reg_rvalid));
        rd_val = reg_rdata;
        @(negedge clk);
        chk("rvalid drop", 72'h0, 72'(reg_rvalid));
    endtask
    function automatic logic [71:0] cfg_vec();
        logic [71:0] v;
        for (int t = 0; t < 8; t++) v[9*t +: 9] = 9'(cfg_m[t]);
        return v;
    endfunction
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==========================================================
    // clock, watchdog, sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        errors++;
        print_verdict();
    end
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, passed, done, late, level} = '0;
        rst = 1'b1;
        void'($urandom(23394));
        repeat (4) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("cfg after reset", 72'h0, trig_cfg);
        chk("ready after reset", 72'h1, 72'(evt_ready));
        rd(TRIG_CFG_ADDR);
        chk("trig page0", 72'h0, 72'(rd_val));
        wr(PAGE_SEL_ADDR, 16'h0005);
        foreach (cfg_m[t]) begin
            w = 16'($urandom);
            cfg_m[t] = int'(w[15:7]);
            wr(TRIG_CFG_ADDR, {w[15:4], 3'(t), 1'b1});
        end
        chk("cfg store", cfg_vec(), trig_cfg);
        wr(PAGE_SEL_ADDR, 16'h0004);
        wr(TRIG_CFG_ADDR, 16'hffff);
        rd(TRIG_CFG_ADDR);
        chk("trig page4", 72'h0, 72'(rd_val));
        chk("cfg off page", cfg_vec(), trig_cfg);
        wr(PAGE_SEL_ADDR, 16'hfff5);
        foreach (cfg_m[t]) begin
            w = 16'($urandom);
            wr(TRIG_CFG_ADDR, {w[15:4], 3'(t), 1'b0});
            rd(TRIG_CFG_ADDR);
            chk("trig read", {56'h0, 9'(cfg_m[t]), 3'h0, 3'(t), 1'b0}, 72'(rd_val));
        end
        chk("cfg after selects", cfg_vec(), trig_cfg);
        repeat (60) begin
            {passed, done, late, level} = $urandom;
            @(negedge clk);
            {fe, re, ge} = '0;
            for (int t = 0; t < 8; t++) begin
                c = cfg_m[t];
                fe[t] = c[F_OVERDUE] & passed[t];
                re[t] = c[F_REPORT] & (done[t] | (late[t] & !(c[F_PERIODIC] & c[F_OVERDUE])));
                if (c[4:1] >= 1 && c[4:1] <= 12) ge[c[4:1]-1] = ge[c[4:1]-1] | level[t];
            end
            chk("fire now", 72'(fe), 72'(fire_now));
            chk("report", 72'(re), 72'(report));
            chk("gpio", 72'(ge), 72'(gpio));
        end
        {passed, done, late} = '0;
        wr(PAGE_SEL_ADDR, 16'h0004);
        for (int i = 0; i < 6; i++) begin
            s = (i == 0) ? 8'h80 : (8'($urandom) | 8'h11);
            d = 8'($urandom) & s;
            m = 3'($urandom);
            n = 30'($urandom);
            sc = $urandom;
            ptp_evt_source_i.offer(s, d, m, n, sc);
            for (int u = 7; u >= 0; u--) if (s[u]) num = 3'(u);
            for (int u = 0; u < 8; u++) ext[2*u +: 2] = {d[u], s[u]};
            st = {5'h0, m, 2'h3, d[num], num, $countones(s) > 1, 1'b1};
            rd(EVT_STS_ADDR);
            chk("status", 72'(st), 72'(rd_val));
            if ($countones(s) > 1) begin
                rd(EVT_DATA_ADDR);
                chk("ext status", 72'(ext), 72'(rd_val));
            end
            rd(EVT_DATA_ADDR);
            chk("ns low", 72'(n[15:0]), 72'(rd_val));
            rd(EVT_DATA_ADDR);
            chk("ns high", {58'h0, n[29:16]}, 72'(rd_val));
            rd(EVT_DATA_ADDR);
            chk("sec low", 72'(sc[15:0]), 72'(rd_val));
            rd(EVT_DATA_ADDR);
            chk("sec high", 72'(sc[31:16]), 72'(rd_val));
            rd(EVT_DATA_ADDR);
            chk("wrap", 72'(n[15:0]), 72'(rd_val));
        end
        rd(EVT_STS_ADDR);
        chk("empty status", 72'h0, 72'(rd_val));
        print_verdict();
    end
endmodule
`default_nettype wire

// ### verif/ptp_event_trigger_regs_sva.sv
// Purpose: port-level checks for the event readout and trigger config block
// Assumes: one CLK domain, RST synchronous active high
// Notes: the page register is shadowed here to qualify trigger accesses
`timescale 1ns/1ps
`default_nettype none
module ptp_event_trigger_regs_sva
    import ptp_regs_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [4:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_WDATA,
    input wire logic [15:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic EVT_VALID,
    input wire logic EVT_READY,
    input wire logic [7:0] TRIG_TIME_PASSED,
    input wire logic [7:0] TRIG_DONE,
    input wire logic [7:0] TRIG_LATE_ERR,
    input wire logic [7:0] TRIG_LEVEL,
    input wire logic [71:0] TRIG_CFG,
    input wire logic [7:0] TRIG_FIRE_NOW,
    input wire logic [7:0] TRIG_REPORT,
    input wire logic [11:0] GPIO_OUT
);
    logic [2:0] page_reg;
    logic [2:0] page_next;
    logic [7:0] ovr, per, rep;
    logic [11:0] gexp;
    logic commit;

    // ==========================================================
    // helper logic
    always_comb begin
        page_next = page_reg;
        if (REG_WR && REG_ADDR == PAGE_SEL_ADDR) begin
            page_next = REG_WDATA[2:0];
        end
    end
    always_ff @(posedge CLK) begin
        page_reg <= RST ? PAGE_RST : page_next;
    end
    always_comb begin
        gexp = 12'h000;
        for (int t = 0; t < 8; t++) begin
            ovr[t] = TRIG_CFG[9*t+F_OVERDUE];
            per[t] = TRIG_CFG[9*t+F_PERIODIC];
            rep[t] = TRIG_CFG[9*t+F_REPORT];
            for (int g = 1; g <= 12; g++) begin
                if (TRIG_CFG[9*t+F_ROUTE_LSB +: 4] == 4'(g)) begin
                    gexp[g-1] = gexp[g-1] | TRIG_LEVEL[t];
                end
            end
        end
    end
    assign commit = REG_WR && REG_ADDR == TRIG_CFG_ADDR && page_reg == PAGE_CFG && REG_WDATA[0];

    // ==========================================================
    // properties
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    property p_read_answer; REG_RD |=> REG_RVALID; endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read got no answer one cycle later");
    property p_trig_page;
        REG_RD && REG_ADDR == TRIG_CFG_ADDR && page_reg != PAGE_CFG |=> REG_RDATA == 16'h0000;
    endproperty
    a_trig_page: assert property (p_trig_page)
        else $error("trigger register answered off its page");
    property p_trig_zero;
        REG_RD && REG_ADDR == TRIG_CFG_ADDR |=> REG_RDATA[6:4] == 3'h0 && !REG_RDATA[0];
    endproperty
    a_trig_zero: assert property (p_trig_zero)
        else $error("reserved or commit bit read nonzero");
    property p_commit_load;
        commit |=> TRIG_CFG[int'($past(REG_WDATA[3:1]))*9 +: 9] == $past(REG_WDATA[15:7]);
    endproperty
    a_commit_load: assert property (p_commit_load)
        else $error("commit write not stored in selected trigger");
    property p_cfg_hold; !commit |=> $stable(TRIG_CFG); endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("trigger config changed without commit");
    property p_fire; 1'b1 |=> TRIG_FIRE_NOW == $past(ovr & TRIG_TIME_PASSED); endproperty
    a_fire: assert property (p_fire)
        else $error("fire-now differs from overdue and passed");
    property p_report;
        1'b1 |=> TRIG_REPORT == $past(rep & (TRIG_DONE | (TRIG_LATE_ERR & ~(per & ovr))));
    endproperty
    a_report: assert property (p_report)
        else $error("report output wrong");
    property p_gpio; 1'b1 |=> GPIO_OUT == $past(gexp); endproperty
    a_gpio: assert property (p_gpio)
        else $error("gpio routing wrong");
    property p_evt_take; EVT_VALID && EVT_READY |=> !EVT_READY; endproperty
    a_evt_take: assert property (p_evt_take)
        else $error("ready stayed high after a take");

    c_commit: cover property (commit);
    c_fire: cover property (TRIG_FIRE_NOW != 8'h00);
    c_take: cover property (EVT_VALID && EVT_READY);
endmodule

bind ptp_event_trigger_regs ptp_event_trigger_regs_sva ptp_event_trigger_regs_sva_i (
    .CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .EVT_VALID(EVT_VALID), .EVT_READY(EVT_READY), .TRIG_TIME_PASSED(TRIG_TIME_PASSED),
    .TRIG_DONE(TRIG_DONE), .TRIG_LATE_ERR(TRIG_LATE_ERR), .TRIG_LEVEL(TRIG_LEVEL),
    .TRIG_CFG(TRIG_CFG), .TRIG_FIRE_NOW(TRIG_FIRE_NOW), .TRIG_REPORT(TRIG_REPORT),
    .GPIO_OUT(GPIO_OUT));
`default_nettype wire

// ### verif/ptp_evt_source.sv
// Purpose: capture-side model offering event timestamps to the block
// Assumes: fields change only on the falling edge
// Notes: released fields are inverted so a stale value never looks valid
`timescale 1ns/1ps
`default_nettype none
module ptp_evt_source (
    input wire logic CLK,
    input wire logic EVT_READY,
    output logic EVT_VALID,
    output logic [7:0] EVT_SEEN,
    output logic [7:0] EVT_DIR,
    output logic [2:0] EVT_MISSED,
    output logic [29:0] EVT_NS,
    output logic [31:0] EVT_SEC
);
    initial begin
        EVT_VALID = 1'b0;
        {EVT_SEEN, EVT_DIR, EVT_MISSED, EVT_NS, EVT_SEC} = '0;
    end

    // all fields stay put until the slot is taken, or for 51 cycles if ready never rises
    task automatic offer(input logic [7:0] s, input logic [7:0] d, input logic [2:0] m,
                         input logic [29:0] n, input logic [31:0] c);
        @(negedge CLK);
        EVT_VALID = 1'b1;
        {EVT_SEEN, EVT_DIR, EVT_MISSED, EVT_NS, EVT_SEC} = {s, d, m, n, c};
        // ready is looked at mid-cycle, where it has settled
        repeat (50) begin
            if (EVT_READY === 1'b1) break;
            @(negedge CLK);
        end
        @(negedge CLK);
        EVT_VALID = 1'b0;
        {EVT_SEEN, EVT_DIR, EVT_MISSED, EVT_NS, EVT_SEC} = ~{s, d, m, n, c};
    endtask
endmodule
`default_nettype wire
